// >>> sli_cfg.svh
`ifndef SLI_CFG_SVH
`define SLI_CFG_SVH
// register byte offsets
`define SLI_REG_CTRL 12'h000
`define SLI_REG_STAT 12'h004
`define SLI_REG_STREN 12'h008
`define SLI_REG_BAUD 12'h00c
`define SLI_REG_HOP 12'h010
// ctrl fields
`define SLI_CTRL_DATA_BIT 0
`define SLI_CTRL_ROLE_LSB 1
`define SLI_CTRL_FAST_BIT 3
`define SLI_CTRL_BAUD_LSB 4
`define SLI_CTRL_RESET 32'h00000000
// hop interval default (cycles); rx takes the first half
`define SLI_HOP_RESET 32'h000186a0
// timing
`define SLI_CLK_HZ 25000000
`define SLI_CYCLE_MS 300
`define SLI_SILENT_MS 2000
`define SLI_CYCLE_TICKS ((`SLI_CLK_HZ / 1000) * `SLI_CYCLE_MS)
`define SLI_SILENT_TICKS ((`SLI_CLK_HZ / 1000) * `SLI_SILENT_MS)
// serial rates
`define SLI_BAUD_CFG 9600
`define SLI_BAUD_DIAG 115200
`define SLI_BAUD_MIN 300
`define SLI_BAUD_MAX 230400
// strength thresholds (average of four)
`define SLI_THR1 8'h40
`define SLI_THR2 8'h80
`define SLI_THR3 8'hc0
`endif

// >>> sli_led_panel.sv
/*
 front-panel model: counts lit bar segments.
 assumes the block drives the lamps directly.
*/
`timescale 1ns/1ps
// ----------
// panel
// ----------
module sli_led_panel (
	// lamps from the block
	input wire sli_pkg::sli_leds_t leds,
	// segments a viewer sees
	output logic [1:0] lit_count
);
	always_comb
	begin
		lit_count = 2'(leds.bar[0]) + 2'(leds.bar[1]) + 2'(leds.bar[2]);
	end
endmodule

// >>> sli_pkg.sv
/*
 types for the status led indicator block.
 assumes sli_cfg.svh is included by users.
*/
package sli_pkg;
	typedef enum logic [1:0] {
		SLI_MASTER = 2'h0,
		SLI_REPEATER = 2'h1,
		SLI_SLAVE = 2'h2
	} sli_role_t;
	typedef struct packed {
		logic sys;
		logic tx;
		logic rx;
		logic [2:0] bar;
	} sli_leds_t;
	typedef struct packed {
		logic valid;
		logic from_master;
		logic [7:0] level;
	} sli_pkt_t;
endpackage

// >>> sli_status_led.sv
/*
 status led and mode-entry logic with an apb register file.
 assumes mclk at 25 mhz, pins synchronised here, radio core on mclk.
*/
// The APB interface to the registers and the register offsets were left to the implementer.
// Notes on behaviour
// - System status LED is lit while powered and core health is good.
// - Command mode leaves only the status LED lit in every role.
// - Transmit LED shows radio transmission.
// - Receive/sync LED shows sync with valid packets received.
// - Strength is a three-LED bar filling from the leftmost LED.
// - Strength comes from the four latest crc-good packets only.
// - The computed strength is readable in a strength register.
// - Master in data mode: rx on valid packets, tx on, bar 1-3.
// - Fast sync or acquisition: bar cycles 300 ms, rx off, tx per role.
// - Synced repeater: rx in first part of hop, tx in second part.
// - Synced repeater bar 1-2 from slaves, master after 2 s silence.
// - Synced slave: rx on, tx on sending, bar 1-3 from upstream.
// - Button held at power-up boots command mode at 9600 bps.
// - Diagnostics port runs at 115.2 kbps without text commands.
// - Main port carries data at 300-230400 bps, config in command mode.
// - Device shuts down while the active-low off input is low.
`timescale 1ns/1ps
`include "sli_cfg.svh"
module sli_status_led (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins
	input wire logic config_button_n,
	input wire logic power_off_input_n,
	// radio core status
	input wire logic core_ok,
	input wire logic synced,
	input wire logic tx_active,
	input wire sli_pkg::sli_pkt_t pkt,
	// indicators and controls
	output sli_pkg::sli_leds_t leds,
	output logic shutdown,
	output logic diag_cmds_enable,
	output logic [17:0] main_baud,
	output logic [17:0] diag_baud
);
	//--------------------------------------------------
	// pin synchronisers
	//--------------------------------------------------
	logic [1:0] btn_sync_ff, off_sync_ff;
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			btn_sync_ff <= 2'h3;
			off_sync_ff <= 2'h3;
		end
		else
		begin
			btn_sync_ff <= {btn_sync_ff[0], config_button_n};
			off_sync_ff <= {off_sync_ff[0], power_off_input_n};
		end
	end

	//--------------------------------------------------
	// registers
	//--------------------------------------------------
	logic data_mode_ff;
	logic [1:0] role_ff;
	logic fast_ff;
	logic [17:0] baud_ff;
	logic [31:0] hop_ff;
	logic [1:0] boot_cnt_ff;
	logic wr_en;
	logic [7:0] avg_slave, avg_master, strength;
	logic [31:0] rd_mux;
	logic map_hit;

	function automatic logic [17:0] clamp_baud(input logic [31:0] v);
		if (v < 32'(`SLI_BAUD_MIN))
			return 18'(`SLI_BAUD_MIN);
		else if (v > 32'(`SLI_BAUD_MAX))
			return 18'(`SLI_BAUD_MAX);
		else
			return v[17:0];
	endfunction

	assign wr_en = psel && penable && pwrite;
	always_comb
	begin
		map_hit = 1'b1;
		rd_mux = 32'h00000000;
		case (paddr)
			`SLI_REG_CTRL: rd_mux = {28'h0, fast_ff, role_ff, data_mode_ff};
			`SLI_REG_STAT: rd_mux = {26'h0, !off_sync_ff[1], synced,
				leds.rx, leds.tx, leds.sys, core_ok};
			`SLI_REG_STREN: rd_mux = {24'h0, strength};
			`SLI_REG_BAUD: rd_mux = {14'h0, baud_ff};
			`SLI_REG_HOP: rd_mux = hop_ff;
			default: map_hit = 1'b0;
		endcase
	end

	// mode control; strap caught once the synchroniser has filled
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			data_mode_ff <= 1'b0;
			role_ff <= 2'h0;
			fast_ff <= 1'b0;
			baud_ff <= 18'(`SLI_BAUD_CFG);
			boot_cnt_ff <= 2'h0;
		end
		else if (boot_cnt_ff != 2'h3)
		begin
			boot_cnt_ff <= boot_cnt_ff + 2'h1;
			if (boot_cnt_ff == 2'h2)
				data_mode_ff <= btn_sync_ff[1];
			baud_ff <= 18'(`SLI_BAUD_CFG);
		end
		else if (wr_en && paddr == `SLI_REG_CTRL)
		begin
			data_mode_ff <= pwdata[`SLI_CTRL_DATA_BIT];
			role_ff <= pwdata[`SLI_CTRL_ROLE_LSB +: 2];
			fast_ff <= pwdata[`SLI_CTRL_FAST_BIT];
		end
		else if (wr_en && paddr == `SLI_REG_BAUD)
			baud_ff <= clamp_baud(pwdata);
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			hop_ff <= `SLI_HOP_RESET;
		else if (wr_en && paddr == `SLI_REG_HOP && pwdata != 32'h0)
			hop_ff <= pwdata;
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !map_hit;
			prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
		end
	end

	//--------------------------------------------------
	// strength sources
	//--------------------------------------------------
	sli_strength_avg u_avg_slave (
		.mclk(mclk),
		.reset(reset),
		.pkt_valid(pkt.valid && !pkt.from_master),
		.pkt_level(pkt.level),
		.avg_ff(avg_slave)
	);
	sli_strength_avg u_avg_master (
		.mclk(mclk),
		.reset(reset),
		.pkt_valid(pkt.valid && pkt.from_master),
		.pkt_level(pkt.level),
		.avg_ff(avg_master)
	);

	//--------------------------------------------------
	// timers
	//--------------------------------------------------
	logic [23:0] step_cnt_ff;
	logic [1:0] cyc_pos_ff;
	logic [26:0] silent_cnt_ff;
	logic [31:0] hop_cnt_ff;
	logic rx_seen_ff;
	logic acquiring;

	assign acquiring = data_mode_ff && (fast_ff ||
		(role_ff != 2'(sli_pkg::SLI_MASTER) && !synced));

	// bar cycling, one step per 300 ms
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			step_cnt_ff <= 24'h0;
			cyc_pos_ff <= 2'h0;
		end
		else if (!acquiring)
		begin
			step_cnt_ff <= 24'h0;
			cyc_pos_ff <= 2'h0;
		end
		else if (step_cnt_ff == 24'(`SLI_CYCLE_TICKS - 1))
		begin
			step_cnt_ff <= 24'h0;
			cyc_pos_ff <= (cyc_pos_ff == 2'h2) ? 2'h0 : cyc_pos_ff + 2'h1;
		end
		else
			step_cnt_ff <= step_cnt_ff + 24'h1;
	end

	// slave silence timer
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			silent_cnt_ff <= 27'(`SLI_SILENT_TICKS);
		else if (pkt.valid && !pkt.from_master)
			silent_cnt_ff <= 27'h0;
		else if (silent_cnt_ff != 27'(`SLI_SILENT_TICKS))
			silent_cnt_ff <= silent_cnt_ff + 27'h1;
	end

	// hop interval phase
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			hop_cnt_ff <= 32'h0;
		else if (hop_cnt_ff >= hop_ff - 32'h1)
			hop_cnt_ff <= 32'h0;
		else
			hop_cnt_ff <= hop_cnt_ff + 32'h1;
	end

	// master rx indication: packet in the last hop interval
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			rx_seen_ff <= 1'b0;
		else if (pkt.valid && !pkt.from_master)
			rx_seen_ff <= 1'b1;
		else if (hop_cnt_ff == 32'h0)
			rx_seen_ff <= 1'b0;
	end

	//--------------------------------------------------
	// led selection
	//--------------------------------------------------
	function automatic logic [2:0] bar_fill(input logic [7:0] s,
		input logic two_max);
		logic [2:0] b;
		b = 3'h1;
		if (s >= `SLI_THR2)
			b = 3'h3;
		if (s >= `SLI_THR3 && !two_max)
			b = 3'h7;
		return b;
	endfunction

	logic [2:0] nxt_bar;
	logic nxt_tx, nxt_rx;
	logic first_half;

	assign first_half = hop_cnt_ff < (hop_ff >> 1);

	always_comb
	begin
		strength = avg_master;
		if (role_ff == 2'(sli_pkg::SLI_MASTER))
			strength = avg_slave;
		else if (role_ff == 2'(sli_pkg::SLI_REPEATER) &&
			silent_cnt_ff != 27'(`SLI_SILENT_TICKS))
			strength = avg_slave;
	end

	always_comb
	begin
		nxt_bar = 3'h0;
		nxt_tx = 1'b0;
		nxt_rx = 1'b0;
		if (!data_mode_ff || !off_sync_ff[1])
			nxt_bar = 3'h0;
		else if (acquiring)
		begin
			nxt_bar = 3'h1 << cyc_pos_ff;
			nxt_tx = fast_ff && role_ff == 2'(sli_pkg::SLI_MASTER);
		end
		else
			case (role_ff)
				2'(sli_pkg::SLI_MASTER):
				begin
					nxt_rx = rx_seen_ff;
					nxt_tx = 1'b1;
					nxt_bar = bar_fill(strength, 1'b0);
				end
				2'(sli_pkg::SLI_REPEATER):
				begin
					nxt_rx = first_half;
					nxt_tx = !first_half;
					nxt_bar = bar_fill(strength, 1'b1);
				end
				2'(sli_pkg::SLI_SLAVE):
				begin
					nxt_rx = 1'b1;
					nxt_tx = tx_active;
					nxt_bar = bar_fill(strength, 1'b0);
				end
				default: nxt_bar = 3'h0;
			endcase
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			leds <= '0;
			shutdown <= 1'b0;
			diag_cmds_enable <= 1'b0;
			main_baud <= 18'(`SLI_BAUD_CFG);
			diag_baud <= 18'(`SLI_BAUD_DIAG);
		end
		else
		begin
			leds.sys <= core_ok && off_sync_ff[1];
			leds.tx <= nxt_tx;
			leds.rx <= nxt_rx && (synced || role_ff ==
				2'(sli_pkg::SLI_MASTER));
			leds.bar <= nxt_bar;
			shutdown <= !off_sync_ff[1];
			diag_cmds_enable <= 1'b0;
			main_baud <= baud_ff;
			diag_baud <= 18'(`SLI_BAUD_DIAG);
		end
	end
endmodule

// >>> sli_status_led_props.sv
/*
 checker for the status led block, bound to its top.
 assumes one clock and an async active-high reset.
*/
`timescale 1ns/1ps
// ----------
// checker
// ----------
module sli_status_led_props (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// pins and status
	input wire logic power_off_input_n,
	input wire logic core_ok,
	// outputs
	input wire sli_pkg::sli_leds_t leds,
	input wire logic shutdown,
	input wire logic diag_cmds_enable,
	input wire logic [17:0] main_baud,
	input wire logic [17:0] diag_baud
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (reset);
	apb_answer_a: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	apb_phase_a: assert property (pready |-> psel && penable)
		else $error("answer outside access");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without answer");
	sys_off_a: assert property (!core_ok |=> !leds.sys)
		else $error("status lamp lit while core bad");
	bar_shape_a: assert property (leds.bar != 3'h5 && leds.bar != 3'h6)
		else $error("bar has a gap");
	off_entry_a: assert property (!power_off_input_n [*4] |=> shutdown)
		else $error("shutdown late");
	off_exit_a: assert property (power_off_input_n [*4] |=> !shutdown)
		else $error("shutdown stuck");
	dark_off_a: assert property (shutdown && $past(shutdown) |-> leds == '0)
		else $error("lamps lit in shutdown");
	diag_fixed_a: assert property (diag_baud == 18'h1c200 && !diag_cmds_enable)
		else $error("diagnostics port wrong");
	main_range_a: assert property (main_baud >= 18'h0012c && main_baud <= 18'h38400)
		else $error("main rate out of range");
	cover property (shutdown);
	cover property (leds.bar == 3'h7);
	cover property (pslverr);
endmodule
bind sli_status_led sli_status_led_props sli_status_led_props_inst (.*);

// >>> sli_strength_avg.sv
/*
 strength averager over the four latest crc-good packets.
 assumes one-cycle valid pulses from the radio core on mclk.
*/
`timescale 1ns/1ps
`include "sli_cfg.svh"
module sli_strength_avg (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// packet in
	input wire logic pkt_valid,
	input wire logic [7:0] pkt_level,
	// average out
	output logic [7:0] avg_ff
);
	logic [7:0] hist_ff [0:3];
	logic [9:0] sum;

	always_comb
	begin
		sum = 10'(hist_ff[0]) + 10'(hist_ff[1]) + 10'(hist_ff[2])
			+ 10'(hist_ff[3]);
	end

	// only the last four good packets count
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			hist_ff[0] <= 8'h00;
			hist_ff[1] <= 8'h00;
			hist_ff[2] <= 8'h00;
			hist_ff[3] <= 8'h00;
		end
		else if (pkt_valid)
		begin
			hist_ff[0] <= pkt_level;
			hist_ff[1] <= hist_ff[0];
			hist_ff[2] <= hist_ff[1];
			hist_ff[3] <= hist_ff[2];
		end
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			avg_ff <= 8'h00;
		else
			avg_ff <= sum[9:2];
	end
endmodule

// >>> status_led_mode_indicator_tb.sv
/*
 self-checking bench for the status led block.
 assumes apb answers in its access cycle.
*/
`timescale 1ns/1ps
`include "sli_cfg.svh"
module status_led_mode_indicator_tb;
	logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, shutdown, diag_cmds_enable;
	logic config_button_n = 0, power_off_input_n = 1;
	logic core_ok = 1, synced = 0, tx_active = 0;
	sli_pkg::sli_pkt_t pkt = '0;
	sli_pkg::sli_leds_t leds;
	logic [17:0] main_baud, diag_baud;
	logic [1:0] lit;
	int mismatches = 0, checked = 0, n_rx, n_tx;
	// ctrl[11:8] synced tx_active exp_tx exp_rx bar_check bar[2:0]
	logic [11:0] rows [8] = '{12'h0c8, 12'h4c8, 12'h208, 12'h920,
		12'h300, 12'h540, 12'h5f0, 12'h590};
	always #20 mclk = ~mclk;
	sli_status_led sli_status_led_inst (.mclk, .reset, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.config_button_n, .power_off_input_n, .core_ok, .synced,
		.tx_active, .pkt, .leds, .shutdown, .diag_cmds_enable,
		.main_baud, .diag_baud);
	sli_led_panel sli_led_panel_inst (.leds, .lit_count(lit));
	// ----------
	// tasks
	// ----------
	task automatic stop_test;
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
			mismatches++;
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			mismatches++;
			stop_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge mclk);
	endtask
	task automatic send(input logic m, input logic [7:0] l);
		pkt <= {1'b1, m, l};
		@(posedge mclk);
		pkt <= '0;
		@(posedge mclk);
	endtask
	// ----------
	// sequence
	// ----------
	initial
	begin
		repeat (4) @(posedge mclk);
		reset <= 0;
		repeat (2) @(posedge mclk);
		chk(leds, 32'h20);
		chk(main_baud, 32'h2580);
		repeat (2) @(posedge mclk);
		apb(0, `SLI_REG_CTRL, 32'h0);
		chk(rd, 32'h0);
		foreach (rows[i])
		begin
			synced <= rows[i][7];
			tx_active <= rows[i][6];
			apb(1, `SLI_REG_CTRL, 32'(rows[i][11:8]));
			repeat (2) @(posedge mclk);
			chk(leds.tx, rows[i][5]);
			chk(leds.rx, rows[i][4]);
			if (rows[i][3])
				chk(leds.bar, rows[i][2:0]);
		end
		repeat (4) send(1, 8'hc8);
		apb(0, `SLI_REG_STREN, 32'h0);
		chk(rd, 32'hc8);
		chk(leds.bar, 32'h7);
		repeat (3) send(1, 8'h40);
		apb(0, `SLI_REG_STREN, 32'h0);
		chk(rd, 32'h62);
		chk(lit, 32'h1);
		apb(1, `SLI_REG_CTRL, 32'h1);
		repeat (4) send(0, 8'h90);
		apb(0, `SLI_REG_STREN, 32'h0);
		chk(rd, 32'h90);
		chk(leds, 32'h3b);
		apb(1, `SLI_REG_CTRL, 32'h3);
		apb(1, `SLI_REG_HOP, 32'h14);
		apb(1, `SLI_REG_HOP, 32'h0);
		apb(0, `SLI_REG_HOP, 32'h0);
		chk(rd, 32'h14);
		repeat (4) send(0, 8'hff);
		chk(leds.bar, 32'h3);
		n_rx = 0;
		n_tx = 0;
		repeat (40)
		begin
			@(posedge mclk);
			n_rx += leds.rx;
			n_tx += leds.tx;
		end
		chk(n_rx, 32'h14);
		chk(n_tx, 32'h14);
		apb(1, `SLI_REG_BAUD, 32'h64);
		apb(0, `SLI_REG_BAUD, 32'h0);
		chk(rd, 32'h12c);
		apb(1, `SLI_REG_BAUD, 32'h493e0);
		apb(0, `SLI_REG_BAUD, 32'h0);
		chk(rd, 32'h38400);
		chk(main_baud, 32'h38400);
		chk(diag_baud, 32'h1c200);
		chk(diag_cmds_enable, 32'h0);
		apb(0, 12'h100, 32'h0);
		chk(er, 32'h1);
		chk(rd, 32'h0);
		core_ok <= 0;
		repeat (3) @(posedge mclk);
		chk(leds.sys, 32'h0);
		core_ok <= 1;
		power_off_input_n <= 0;
		repeat (6) @(posedge mclk);
		chk({shutdown, leds}, 32'h40);
		power_off_input_n <= 1;
		repeat (6) @(posedge mclk);
		chk(shutdown, 32'h0);
		config_button_n <= 1;
		reset <= 1;
		repeat (4) @(posedge mclk);
		reset <= 0;
		repeat (4) @(posedge mclk);
		apb(0, `SLI_REG_CTRL, 32'h0);
		chk(rd[0], 32'h1);
		stop_test();
	end
endmodule
